// ---- core/indicator_pkg.sv ----
// Constants, types and defaults for the port status indicator driver
// What this block does
// (R1) Each pin shows physical-layer state or a software-forced level; the forced level replaces it.
// (R2) Software override forces any parallel pin on, off or flashing.
// (R3) Short events on steady indicators are held visible for one shared programmable duration, 170 ms.
// (R4) Multi-event indicators flash with one shared programmable half period, 84 ms.
// (R5) Three parallel pins per port; a select setting picks each pin's status.
// (R6) Strap mode sets default pin 2/1/0 mapping after reset.
// (R7) Collision indicator low while held collision activity present.
// (R8) Error indicator low after held jabber, receive or buffer error.
// (R9) Duplex low full, speed low 100, link low up.
// (R10) Transmit, receive, activity indicators low while held activity present.
// (R11) Duplex/collision shows duplex, flashes on held collision.
// (R12) Link/receive shows link, flashes on held receive activity.
// (R13) Flashing activity indicator high idle, flashes on held activity.
// (R14) Serial stream carries up to seven indicators per port.
// (R15) Serial uses data, shift-enable and clock pins; strap picks serial defaults.
// (R16) Software selects serial statuses, their hold and flash timing.
// (R17) Serial starts single mode from strap; software selects dual per slot.
// (R18) Single mode: same value in both slots, enable over first slot only.
// (R19) Dual mode: separate 100/10 values, enable over both; off slot none.
// (R20) Port 5 sent first down to port 0; each bit at least 80 ns.
// (R21) Stream refreshed every programmable interval, 42 ms; idle between.
// (R22) Receiver shifts only while shift-enable high.
// (R23) All timers run from the core clock and clear on reset.
package indicator_pkg;
    // Timing
    localparam int CLK_NS  = 50;
    localparam int MS_NS   = 1000000;
    localparam int MS_CYC  = MS_NS / CLK_NS;
    localparam int BIT_NS  = 80;
    localparam int BIT_CYC = (BIT_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] HOLD_MS_RST    = 8'hAA; // 170 ms
    localparam logic [7:0] FLASH_MS_RST   = 8'h54; // 84 ms
    localparam logic [7:0] REFRESH_MS_RST = 8'h2A; // 42 ms
    // Geometry
    localparam int NPORT_SER = 6;
    localparam int NPORT_PAR = 5;
    localparam int NSLOT     = 7;
    localparam int NBITS     = NPORT_SER * NSLOT * 2;
    // Register offsets
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] PARSEL_OFS  = 8'h04;
    localparam logic [7:0] OVR_OFS     = 8'h08;
    localparam logic [7:0] SERSEL_OFS  = 8'h0C;
    localparam logic [7:0] SERDUAL_OFS = 8'h10;
    localparam logic [7:0] STAT_OFS    = 8'h14;
    localparam int HOLD_LSB    = 0;
    localparam int FLASH_LSB   = 8;
    localparam int REFRESH_LSB = 16;
    localparam logic [29:0] OVR_RST     = 30'h0;
    localparam logic [6:0]  SERDUAL_RST = 7'h0;
    // Override codes
    localparam logic [1:0] OVR_NORMAL = 2'h0;
    localparam logic [1:0] OVR_OFF    = 2'h1;
    localparam logic [1:0] OVR_ON     = 2'h2;
    localparam logic [1:0] OVR_FLASH  = 2'h3;
    typedef enum logic [3:0] {
        ST_OFF = 4'h0, ST_COL = 4'h1, ST_ERR = 4'h2, ST_DUP = 4'h3,
        ST_DUPCOL = 4'h4, ST_SPD = 4'h5, ST_LNK = 4'h6, ST_TX = 4'h7,
        ST_RX = 4'h8, ST_ACT = 4'h9, ST_LNKRX = 4'hA, ST_LNKACT = 4'hB,
        ST_ACTFL = 4'hC
    } status_e;
    // Strap defaults, pin 2 in [11:8] down to pin 0 in [3:0]
    localparam logic [11:0] PAR_DEF [4] = '{12'h687, 12'h695, 12'hA75, 12'hB45};
    // Serial defaults, slot 0 in [3:0]
    localparam logic [27:0] SER_DEF [4] =
        '{28'h000B542, 28'h0A75321, 28'h0965321, 28'h8765321};
endpackage : indicator_pkg

// ---- core/event_hold.sv ----
// Per-lane pulse stretcher with a shared hold duration
`timescale 1ns/10ps
module event_hold import indicator_pkg::*; #(
    parameter int W = 6
) (
    input  wire logic         clock,
    input  wire logic         reset,
    input  wire logic         clock_en,
    input  wire logic         tick,
    input  wire logic [W-1:0] event_in,
    input  wire logic [7:0]   len,
    output logic      [W-1:0] held
);
    logic [7:0]   cnt_q [W];
    logic [W-1:0] held_q;

    // Reload on event, count down on millisecond ticks
    always_ff @(posedge clock) begin
        for (int i = 0; i < W; i++) begin
            if (reset) begin
                cnt_q[i]  <= 8'h00; // R23
                held_q[i] <= 1'b0;
            end else if (clock_en) begin
                if (event_in[i]) begin
                    cnt_q[i]  <= len; // R3
                    held_q[i] <= 1'b1;
                end else if (tick && cnt_q[i] != 8'h00) begin
                    cnt_q[i]  <= cnt_q[i] - 8'h01;
                    held_q[i] <= cnt_q[i] != 8'h01;
                end
            end
        end
    end
    assign held = held_q;

    AST_HOLD_SET: assert property (@(posedge clock) disable iff (reset || !clock_en)
        event_in[0] |=> held_q[0]) // R7
        else $error("event not held");
    AST_HOLD_END: assert property (@(posedge clock) disable iff (reset || !clock_en)
        tick && !event_in[0] && cnt_q[0] == 8'h01 |=> !held_q[0]) // R3
        else $error("hold did not expire");
endmodule : event_hold

// ---- core/stream_sequencer.sv ----
// Serial indicator frame sequencer: refresh timer and bit shifter
`timescale 1ns/10ps
module stream_sequencer import indicator_pkg::*; (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       clock_en,
    input  wire logic       tick,
    input  wire logic [7:0] interval,
    input  wire logic       bit_data,
    input  wire logic       bit_en,
    output logic      [6:0] index,
    output logic            ser_out,
    output logic            shift_en,
    output logic            shift_clk,
    output logic            busy
);
    typedef enum logic {S_IDLE = 1'b0, S_SHIFT = 1'b1} seq_e;
    seq_e       st_q;
    logic [7:0] wait_q;
    logic [6:0] idx_q;
    logic [1:0] ph_q;
    logic       ser_q, en_q, clk_q;

    wire last_ph  = ph_q == 2'(BIT_CYC - 1);
    wire last_bit = idx_q == 7'(NBITS - 1);

    // Refresh wait, then one frame of bits
    always_ff @(posedge clock) begin
        if (reset) begin
            st_q <= S_IDLE; wait_q <= 8'h00; idx_q <= 7'h00; ph_q <= 2'h0;
            ser_q <= 1'b1; en_q <= 1'b0; clk_q <= 1'b0;
        end else if (clock_en) begin
            unique case (st_q)
                S_IDLE: begin
                    en_q <= 1'b0;
                    clk_q <= 1'b0;
                    if (tick) wait_q <= wait_q + 8'h01;
                    if (tick && wait_q + 8'h01 >= interval) begin // R21
                        wait_q <= 8'h00;
                        st_q   <= S_SHIFT;
                    end
                end
                S_SHIFT: begin
                    ph_q <= last_ph ? 2'h0 : ph_q + 2'h1;
                    if (ph_q == 2'h0) begin
                        ser_q <= bit_data; // R20
                        en_q  <= bit_en;   // R22
                        clk_q <= 1'b0;
                    end
                    if (ph_q == 2'(BIT_CYC / 2)) clk_q <= 1'b1;
                    if (last_ph) begin
                        idx_q <= last_bit ? 7'h00 : idx_q + 7'h01;
                        if (last_bit) st_q <= S_IDLE;
                    end
                end
            endcase
        end
    end
    assign index     = idx_q;
    assign ser_out   = ser_q;
    assign shift_en  = en_q;
    assign shift_clk = clk_q;
    assign busy      = st_q == S_SHIFT;

    AST_BIT_TIME: assert property (@(posedge clock) disable iff (reset || !clock_en)
        $rose(clk_q) |-> $past(en_q) == en_q && $past(ser_q) == ser_q) // R20
        else $error("data moved at shift clock edge");
    AST_IDLE_QUIET: assert property (@(posedge clock) disable iff (reset || !clock_en)
        st_q == S_IDLE && $past(st_q) == S_IDLE |-> !en_q && !clk_q) // R21
        else $error("shifting outside a frame");
    COV_FRAME: cover property (@(posedge clock) st_q == S_SHIFT && last_bit && last_ph);
endmodule : stream_sequencer

// ---- core/port_indicator_driver.sv ----
// Port status indicator driver: parallel pins, serial stream, APB registers
`timescale 1ns/10ps
module port_indicator_driver import indicator_pkg::*; #(
    parameter int MS_TICK = MS_CYC
) (
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire logic                 clock_en,
    input  wire logic [7:0]           paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [1:0]           strap_mode,
    input  wire logic [NPORT_SER-1:0] link_up,
    input  wire logic [NPORT_SER-1:0] speed_100,
    input  wire logic [NPORT_SER-1:0] full_duplex,
    input  wire logic [NPORT_SER-1:0] tx_activity,
    input  wire logic [NPORT_SER-1:0] rx_activity,
    input  wire logic [NPORT_SER-1:0] collision,
    input  wire logic [NPORT_SER-1:0] error_event,
    output logic      [NPORT_PAR-1:0] port_indicator_two,
    output logic      [NPORT_PAR-1:0] port_indicator_one,
    output logic      [NPORT_PAR-1:0] port_indicator_zero,
    output logic                      indicator_serial_out,
    output logic                      indicator_shift_enable,
    output logic                      indicator_shift_clock
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (reset || !clock_en);

    // Registers
    logic [31:0] prdata_q;
    logic        pready_q, pslverr_q;
    logic [7:0]  hold_ms_q, flash_ms_q, refresh_ms_q;
    logic [11:0] par_sel_q;
    logic [29:0] ovr_q;
    logic [27:0] ser_sel_q;
    logic [6:0]  ser_dual_q;
    logic [1:0]  strap_s1_q, strap_s2_q, mode_q;
    logic        loaded_q;
    logic [19:0] ms_cnt_q;
    logic        tick_q;
    logic [7:0]  flash_cnt_q;
    logic        flash_q;
    logic [14:0] pin_q;

    // Strap synchroniser, no reset so it is valid at release
    always_ff @(posedge clock) begin
        if (clock_en) begin
            strap_s1_q <= strap_mode;
            strap_s2_q <= strap_s1_q;
        end
    end

    // Millisecond tick from the core clock
    always_ff @(posedge clock) begin
        if (reset) begin
            ms_cnt_q <= 20'h00000; // R23
            tick_q   <= 1'b0;
        end else if (clock_en) begin
            tick_q   <= ms_cnt_q == 20'(MS_TICK - 1);
            ms_cnt_q <= (ms_cnt_q == 20'(MS_TICK - 1)) ? 20'h00000 : ms_cnt_q + 20'h00001;
        end
    end

    // Shared flash phase, high half then low half
    always_ff @(posedge clock) begin
        if (reset) begin
            flash_cnt_q <= 8'h00; // R23
            flash_q     <= 1'b1;
        end else if (clock_en && tick_q) begin
            if (flash_cnt_q + 8'h01 >= flash_ms_q) begin
                flash_cnt_q <= 8'h00;
                flash_q     <= !flash_q; // R4
            end else begin
                flash_cnt_q <= flash_cnt_q + 8'h01;
            end
        end
    end

    // Held events: long hold for steady pins, flash period for flashing ones
    logic [29:0] long_h;
    logic [17:0] short_h;
    event_hold #(.W(30)) u_long (
        .clock    (clock),
        .reset    (reset),
        .clock_en (clock_en),
        .tick     (tick_q),
        .event_in ({tx_activity | rx_activity, rx_activity, tx_activity,
                    error_event, collision}),
        .len      (hold_ms_q),
        .held     (long_h)
    );
    event_hold #(.W(18)) u_short (
        .clock    (clock),
        .reset    (reset),
        .clock_en (clock_en),
        .tick     (tick_q),
        .event_in ({tx_activity | rx_activity, rx_activity, collision}),
        .len      (flash_ms_q),
        .held     (short_h)
    );

    // Held event slices
    wire [5:0] col_l = long_h[5:0];
    wire [5:0] err_l = long_h[11:6];
    wire [5:0] tx_l  = long_h[17:12];
    wire [5:0] rx_l  = long_h[23:18];
    wire [5:0] act_l = long_h[29:24];
    wire [5:0] col_s = short_h[5:0];
    wire [5:0] rx_s  = short_h[11:6];
    wire [5:0] act_s = short_h[17:12];

    // Pin level for one status code; low is lit
    function automatic logic level(input logic [3:0] c, input int p, input logic fl);
        logic l;
        l = 1'b1;
        case (status_e'(c))
            ST_OFF:    l = 1'b1;
            ST_COL:    l = !col_l[p];                      // R7
            ST_ERR:    l = !err_l[p];                      // R8
            ST_DUP:    l = !full_duplex[p];                // R9
            ST_DUPCOL: l = col_s[p] ? fl : !full_duplex[p]; // R11
            ST_SPD:    l = !speed_100[p];                  // R9
            ST_LNK:    l = !link_up[p];                    // R9
            ST_TX:     l = !tx_l[p];                       // R10
            ST_RX:     l = !rx_l[p];                       // R10
            ST_ACT:    l = !act_l[p];                      // R10
            ST_LNKRX:  l = rx_s[p] ? fl : !link_up[p];     // R12
            ST_LNKACT: l = act_s[p] ? fl : !link_up[p];
            ST_ACTFL:  l = act_s[p] ? fl : 1'b1;           // R13
            default:   l = 1'b1;
        endcase
        return l;
    endfunction : level

    // Status level per parallel pin; a process sees the held events the function reads
    logic [14:0] pin_d;
    logic [14:0] phy_lvl;
    always_comb begin
        phy_lvl = '1;
        for (int i = 0; i < 15; i++) begin
            phy_lvl[i] = level(par_sel_q[4*(i%3) +: 4], i / 3, flash_q); // R5 R1
        end
    end

    // Parallel pins: select, then override
    for (genvar p = 0; p < NPORT_PAR; p++) begin : g_par
        for (genvar k = 0; k < 3; k++) begin : g_pin
            wire [1:0] ov   = ovr_q[2*(3*p+k) +: 2];
            wire       phy  = phy_lvl[3*p+k];                      // R1
            assign pin_d[3*p+k] = (ov == OVR_NORMAL) ? phy :       // R2
                                  (ov == OVR_OFF)    ? 1'b1 :
                                  (ov == OVR_ON)     ? 1'b0 : flash_q;
        end
        assign port_indicator_zero[p] = pin_q[3*p];
        assign port_indicator_one[p]  = pin_q[3*p+1];
        assign port_indicator_two[p]  = pin_q[3*p+2];
    end

    // Pin flops
    always_ff @(posedge clock) begin
        if (reset) pin_q <= '1;
        else if (clock_en) pin_q <= pin_d;
    end

    // Serial bit select: port 5 first, seven slots, 100 then 10
    logic [6:0] ser_idx;
    logic       ser_busy;
    wire  [6:0] grp      = ser_idx / 7'd14;
    wire  [6:0] rem      = ser_idx % 7'd14;
    wire  [2:0] ser_port = 3'(7'd5 - grp);                         // R20
    wire  [2:0] slot     = rem[3:1];                               // R14
    wire        sub10    = rem[0];
    wire  [3:0] ser_code = ser_sel_q[{slot, 2'b00} +: 4];          // R16
    wire        dual     = ser_dual_q[slot];                       // R17
    logic       ser_lvl;
    // Status level of the serial bit in flight
    always_comb begin
        ser_lvl = level(ser_code, int'(ser_port), flash_q);
    end
    wire        sp100    = speed_100[ser_port];
    wire        bit_data = !dual ? ser_lvl :                       // R18
                           (sub10 ? (ser_lvl | sp100) : (ser_lvl | !sp100)); // R19
    wire        bit_en   = ser_code != ST_OFF && (dual || !sub10); // R18 R19

    stream_sequencer u_seq (
        .clock     (clock),
        .reset     (reset),
        .clock_en  (clock_en),
        .tick      (tick_q),
        .interval  (refresh_ms_q),
        .bit_data  (bit_data),
        .bit_en    (bit_en),
        .index     (ser_idx),
        .ser_out   (indicator_serial_out),   // R15
        .shift_en  (indicator_shift_enable),
        .shift_clk (indicator_shift_clock),
        .busy      (ser_busy)
    );

    // APB decode
    wire access = psel && penable && pready_q;
    wire wr     = access && pwrite;
    wire hit    = paddr == CTRL_OFS || paddr == PARSEL_OFS || paddr == OVR_OFS ||
                  paddr == SERSEL_OFS || paddr == SERDUAL_OFS || paddr == STAT_OFS;
    wire [31:0] rd_mux =
        (paddr == CTRL_OFS)    ? {8'h00, refresh_ms_q, flash_ms_q, hold_ms_q} :
        (paddr == PARSEL_OFS)  ? {20'h00000, par_sel_q} :
        (paddr == OVR_OFS)     ? {2'h0, ovr_q} :
        (paddr == SERSEL_OFS)  ? {4'h0, ser_sel_q} :
        (paddr == SERDUAL_OFS) ? {25'h0000000, ser_dual_q} :
        (paddr == STAT_OFS)    ? {23'h000000, ser_busy, mode_q, link_up} : 32'h00000000;

    // APB answer: ready one cycle into the access phase
    always_ff @(posedge clock) begin
        if (reset) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else if (clock_en) begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !hit;
            prdata_q  <= (psel && penable && !pready_q && !pwrite) ? rd_mux : 32'h00000000;
        end
    end
    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // Timing registers
    always_ff @(posedge clock) begin
        if (reset) begin
            hold_ms_q    <= HOLD_MS_RST;
            flash_ms_q   <= FLASH_MS_RST;
            refresh_ms_q <= REFRESH_MS_RST;
        end else if (clock_en && wr && paddr == CTRL_OFS) begin
            hold_ms_q    <= pwdata[HOLD_LSB +: 8];    // R3
            flash_ms_q   <= pwdata[FLASH_LSB +: 8];   // R4
            refresh_ms_q <= pwdata[REFRESH_LSB +: 8]; // R21
        end
    end

    // Display selection: strap defaults once after reset, then software
    always_ff @(posedge clock) begin
        if (reset) begin
            loaded_q   <= 1'b0;
            mode_q     <= 2'h0;
            par_sel_q  <= PAR_DEF[0];
            ser_sel_q  <= SER_DEF[0];
            ser_dual_q <= SERDUAL_RST;
            ovr_q      <= OVR_RST;
        end else if (clock_en) begin
            if (!loaded_q) begin
                loaded_q   <= 1'b1;
                mode_q     <= strap_s2_q;
                par_sel_q  <= PAR_DEF[strap_s2_q]; // R6
                ser_sel_q  <= SER_DEF[strap_s2_q]; // R15
                ser_dual_q <= SERDUAL_RST;         // R17
            end else if (wr) begin
                if (paddr == PARSEL_OFS)  par_sel_q  <= pwdata[11:0];
                if (paddr == OVR_OFS)     ovr_q      <= pwdata[29:0];
                if (paddr == SERSEL_OFS)  ser_sel_q  <= pwdata[27:0];
                if (paddr == SERDUAL_OFS) ser_dual_q <= pwdata[6:0];
            end
        end
    end

    AST_OVR_ON: assert property (
        ovr_q[1:0] == OVR_ON && $past(ovr_q[1:0]) == OVR_ON |-> !pin_q[0]) // R2
        else $error("forced-on pin not low");
    AST_OVR_OFF: assert property (
        ovr_q[1:0] == OVR_OFF && $past(ovr_q[1:0]) == OVR_OFF |-> pin_q[0]) // R2
        else $error("forced-off pin not high");
    AST_LINK_PIN: assert property (
        par_sel_q[11:8] == ST_LNK && ovr_q[5:4] == OVR_NORMAL |=>
        pin_q[2] == !$past(link_up[0])) // R9
        else $error("link pin wrong level");
    AST_STRAP: assert property (
        !loaded_q ##1 loaded_q |-> par_sel_q == PAR_DEF[mode_q] && ser_dual_q == 7'h00) // R6
        else $error("strap defaults not loaded");
    AST_FLASH_TICK: assert property (
        $changed(flash_q) |-> $past(tick_q)) // R4
        else $error("flash phase moved off a tick");
    AST_APB_PULSE: assert property (
        pready_q |=> !pready_q)
        else $error("ready held over two cycles");
    AST_SINGLE_EN: assert property (
        ser_busy && !dual && sub10 |-> !bit_en) // R18
        else $error("enable over 10 slot in single mode");

    COV_OVR_FLASH: cover property (ovr_q[1:0] == OVR_FLASH ##1 $changed(flash_q));
    COV_DUAL: cover property (ser_busy && dual && bit_en && sub10);
    COV_WRITE: cover property (wr && paddr == CTRL_OFS);
endmodule : port_indicator_driver

// ---- dv/shift_receiver.sv ----
// External serial-in shift register fed by the indicator stream
`timescale 1ns/10ps
module shift_receiver (
    input  wire logic        shift_clock,
    input  wire logic        shift_enable,
    input  wire logic        serial_in,
    output logic      [83:0] captured,
    output int               count
);
    // Start empty
    initial begin
        captured = '0;
        count    = 0;
    end
    // Shift on clock rises, only while enabled
    always @(posedge shift_clock) begin
        if (shift_enable) begin
            captured <= {captured[82:0], serial_in};
            count    <= count + 1;
        end
    end
endmodule : shift_receiver

// ---- dv/test_port_indicator_driver.sv ----
// Self-checking bench for the port status indicator driver
`timescale 1ns/10ps
module test_port_indicator_driver;
    import indicator_pkg::*;
    logic        clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        err;
    logic [5:0]  link_up = 6'h15, speed_100 = 6'h0C, full_duplex = 6'h23;
    logic [5:0]  tx_activity = '0, rx_activity = '0, collision = '0, error_event = '0;
    logic [4:0]  pin2, pin1, pin0;
    logic        ser, sen, sclk;
    logic [83:0] rx_bits;
    int          rx_count, miscompares = 0, checked = 0, cycles = 0;

    port_indicator_driver #(.MS_TICK(4)) port_indicator_driver_i (
        .clock(clock), .reset(reset), .clock_en(1'b1), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .strap_mode(2'h3), .link_up(link_up),
        .speed_100(speed_100), .full_duplex(full_duplex), .tx_activity(tx_activity),
        .rx_activity(rx_activity), .collision(collision), .error_event(error_event),
        .port_indicator_two(pin2), .port_indicator_one(pin1), .port_indicator_zero(pin0),
        .indicator_serial_out(ser), .indicator_shift_enable(sen),
        .indicator_shift_clock(sclk));
    shift_receiver shift_receiver_i (.shift_clock(sclk), .shift_enable(sen),
        .serial_in(ser), .captured(rx_bits), .count(rx_count));

    // Clock and hang guard
    always #25 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %0t word got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_frame(input logic [83:0] got, input logic [83:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %0t frame got %h exp %h", $time, got, exp);
        end
    endtask : chk_frame

    // One APB transfer; request held until pready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do @(negedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        @(posedge clock);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Expected enabled bits for strap mode 3 slots with idle events
    function automatic logic [83:0] exp_frame(input logic [6:0] dual);
        logic [83:0] v;
        logic        b;
        v = '0;
        for (int p = 5; p >= 0; p--) begin
            for (int s = 0; s < 7; s++) begin
                b = (s == 2) ? ~full_duplex[p] : (s == 3) ? ~speed_100[p] :
                    (s == 4) ? ~link_up[p] : 1'b1;
                if (dual[s]) v = {v[81:0], speed_100[p] ? b : 1'b1, speed_100[p] ? 1'b1 : b};
                else v = {v[82:0], b};
            end
        end
        return v;
    endfunction : exp_frame

    // Catch one whole frame after an idle gap
    task automatic frame_check(input logic [6:0] dual);
        int c0;
        int q;
        int n;
        q = 0;
        n = 42 + 6 * $countones(dual);
        while (q < 12) begin
            @(negedge clock);
            q = (sen === 1'b1) ? 0 : q + 1;
        end
        @(posedge sen);
        c0 = rx_count;
        repeat (180) @(posedge clock);
        chk_word(32'(rx_count - c0), 32'(n));
        chk_frame(rx_bits & (~84'h0 >> (84 - n)), exp_frame(dual));
    endtask : frame_check

    initial begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        apb(1'b0, 8'h00, '0);
        chk_word(rd, 32'h002A54AA);
        apb(1'b0, 8'h04, '0);
        chk_word(rd, 32'h00000B45);
        apb(1'b0, 8'h0C, '0);
        chk_word(rd, 32'h08765321);
        apb(1'b0, 8'h14, '0);
        chk_word(rd & 32'hFF, 32'h000000D5);
        apb(1'b0, 8'h40, '0);
        chk_word({rd[30:0], err}, 32'h1);
        $display("test registers done");
        apb(1'b1, 8'h04, 32'h00000645);
        #1;
        chk_word({17'h0, pin2, pin1, pin0}, {17'h0, ~link_up[4:0], ~full_duplex[4:0],
                 ~speed_100[4:0]});
        apb(1'b1, 8'h08, 32'h00001002);
        repeat (3) @(posedge clock);
        #1 chk_word({27'h0, pin0}, 32'h16);
        apb(1'b1, 8'h08, 32'h0);
        $display("test static and override done");
        apb(1'b1, 8'h00, 32'h00080202);
        frame_check(7'h00);
        apb(1'b1, 8'h10, 32'h08);
        frame_check(7'h08);
        $display("test serial done");
        apb(1'b1, 8'h04, 32'h00000127);
        @(posedge clock);
        tx_activity <= 6'h04;
        error_event <= 6'h04;
        collision   <= 6'h04;
        @(posedge clock);
        tx_activity <= '0;
        error_event <= '0;
        collision   <= '0;
        repeat (4) @(posedge clock);
        #1 chk_word({17'h0, pin2, pin1, pin0}, 32'h00006F7B);
        repeat (12) @(posedge clock);
        #1 chk_word({17'h0, pin2, pin1, pin0}, 32'h00007FFF);
        $display("test stretch done");
        finish_test();
    end
endmodule : test_port_indicator_driver
